// ==== rtl/dac_wr_pkg.sv ====
/*
  Package for the dual-bank DAC serial write control block.
  Holds the frame layout, command codes, clear-code encodings and timing constants.
  Assumes the core clock runs at 125 MHz and samples every serial pin.
*/
package dac_wr_pkg;
  // Bits in one write frame.
  localparam int unsigned FRAME_BITS   = 32;
  // Width of the bit counter.
  localparam int unsigned CNT_W        = 6;
  // Number of channels in one bank.
  localparam int unsigned BANK_CH      = 8;
  // DAC code width.
  localparam int unsigned CODE_W       = 12;
  // Frame fields: command [27:24], address [23:20], data [19:8].
  localparam int unsigned CMD_LSB      = 24;
  localparam int unsigned ADDR_LSB     = 20;
  localparam int unsigned DATA_LSB     = 8;
  // Commands.
  localparam logic [3:0]  CMD_WR_IN    = 4'h0;
  localparam logic [3:0]  CMD_WR_UPD   = 4'h3;
  localparam logic [3:0]  CMD_CLR_CODE = 4'h5;
  localparam logic [3:0]  CMD_REF_SET  = 4'h8;
  // Clear-code encodings and their output codes.
  localparam logic [1:0]  CLR_ZERO     = 2'h0;
  localparam logic [1:0]  CLR_MID      = 2'h1;
  localparam logic [1:0]  CLR_FULL     = 2'h2;
  localparam logic [11:0] CODE_ZERO    = 12'h000;
  localparam logic [11:0] CODE_MID     = 12'h800;
  localparam logic [11:0] CODE_FULL    = 12'hfff;
  // Core clock period and the serial clock limit, both in ns.
  localparam int unsigned CORE_PERIOD_NS = 8;
  localparam int unsigned SCLK_MIN_NS    = 20;
  // Least serial clock period in core cycles, rounded up.
  localparam int unsigned SCLK_MIN_CYC   = (SCLK_MIN_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  // Write engine states.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE  = 2'b10
  } wr_state_t;
endpackage

// ==== rtl/frame_buf.sv ====
/*
  Two-entry buffer carrying completed write frames to the register logic.
  Assumes both sides run on core_clk; the draining side may stall.
*/
`timescale 1ns/1ns
module frame_buf #(
  parameter int unsigned WIDTH = 33
) (
  input  wire logic             core_clk,  // Core clock.
  input  wire logic             resetn,    // Asynchronous reset, active low.
  input  wire logic [WIDTH-1:0] in_data,   // Word offered by the filler.
  input  wire logic             in_valid,  // Filler offers a word.
  output logic                  in_ready,  // Room for a word.
  output logic [WIDTH-1:0]      out_data,  // Oldest word.
  output logic                  out_valid, // A word is held.
  input  wire logic             out_ready  // Drainer takes the word.
);
  logic [WIDTH-1:0] mem_r [2];   // Storage, addressed by index.
  logic [WIDTH-1:0] mem_nxt [2]; // Next storage.
  logic             rd_r, rd_nxt;  // Read index.
  logic             wr_r, wr_nxt;  // Write index.
  logic [1:0]       cnt_r, cnt_nxt; // Fill level.
  logic             push, pop;      // Handshake strobes.

  // Flags and pointer updates.
  always_comb begin
    push      = in_valid && (cnt_r != 2'h2);
    pop       = out_ready && (cnt_r != 2'h0);
    in_ready  = (cnt_r != 2'h2);
    out_valid = (cnt_r != 2'h0);
    out_data  = mem_r[rd_r];
    mem_nxt   = mem_r;
    if (push) begin
      mem_nxt[wr_r] = in_data;
    end
    wr_nxt  = push ? ~wr_r : wr_r;
    rd_nxt  = pop ? ~rd_r : rd_r;
    cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  end

  // Registers only.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
      rd_r     <= 1'b0;
      wr_r     <= 1'b0;
      cnt_r    <= 2'h0;
    end else begin
      mem_r <= mem_nxt;
      rd_r  <= rd_nxt;
      wr_r  <= wr_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule // frame_buf

// ==== rtl/dac_serial_wr.sv ====
/*
  Serial write port and output update control for a 16-channel DAC section.
  Assumes all pins are asynchronous to core_clk and the serial clock is much slower.
*/
// Functional notes
// R1 - Frame sync fall arms the shift register
// R2 - Capture 32 bits on falling clock edges
// R3 - Early sync rise discards the frame
// R4 - Low sync: channels 0-7; high: 8-15
// R5 - 32-bit shift register, falling edge sampling
// R6 - Host keeps serial clock at most 50 MHz
// R7 - Load pulse moves pending inputs to outputs
// R8 - Load held low updates automatically
// R9 - Clear acts on its falling edge
// R10 - Load ignored while clear held low
// R11 - Clear loads input and DAC registers
// R12 - Clear code resets to zero scale
// R13 - Internal reference off by default
// R14 - Host asserts one frame sync at once
`timescale 1ns/1ns
module dac_serial_wr (
  input  wire logic                      core_clk,               // Core clock, 125 MHz.
  input  wire logic                      resetn,                 // Asynchronous reset, active low.
  input  wire logic                      frame_sync_low_bank_n,  // Frame sync, channels 0-7, active low.
  input  wire logic                      frame_sync_high_bank_n, // Frame sync, channels 8-15, active low.
  input  wire logic                      dac_serial_clock,       // Serial clock from the host.
  input  wire logic                      dac_serial_input,       // Serial data from the host.
  input  wire logic                      output_load_strobe_n,   // Load strobe, active low.
  input  wire logic                      clear_input_n,          // Clear, falling edge active.
  output logic [dac_wr_pkg::BANK_CH*dac_wr_pkg::CODE_W-1:0] low_bank_outputs,  // DAC codes 0-7.
  output logic [dac_wr_pkg::BANK_CH*dac_wr_pkg::CODE_W-1:0] high_bank_outputs, // DAC codes 8-15.
  output logic                           low_bank_reference_oe,  // Low bank reference pin driven.
  output logic                           high_bank_reference_oe, // High bank reference pin driven.
  output logic                           serial_buffers_on,      // Serial input buffers powered.
  output logic [1:0]                     clear_code_sel          // Current clear-code setting.
);
  localparam int unsigned NCH = 2 * dac_wr_pkg::BANK_CH; // Total channels.
  localparam int unsigned FW  = dac_wr_pkg::FRAME_BITS + 1; // Frame plus bank bit.

  // Two-flop synchronisers: stage one feeds only stage two.
  logic [5:0] s1_r, s2_r;
  logic [5:0] pins;
  assign pins = {frame_sync_low_bank_n, frame_sync_high_bank_n, dac_serial_clock,
                 dac_serial_input, output_load_strobe_n, clear_input_n};
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s1_r <= 6'h3f;
      s2_r <= 6'h3f;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
    end
  end

  logic sy_lo, sy_hi, sy_clk, sy_din, sy_ld, sy_clr;
  assign {sy_lo, sy_hi, sy_clk, sy_din, sy_ld, sy_clr} = s2_r;

  // Previous synchronised levels for edge detection.
  logic clk_d_r, clr_d_r, ld_d_r, lo_d_r, hi_d_r;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      clk_d_r <= 1'b1;
      clr_d_r <= 1'b1;
      ld_d_r  <= 1'b1;
      lo_d_r  <= 1'b1;
      hi_d_r  <= 1'b1;
    end else begin
      clk_d_r <= sy_clk;
      clr_d_r <= sy_clr;
      ld_d_r  <= sy_ld;
      lo_d_r  <= sy_lo;
      hi_d_r  <= sy_hi;
    end
  end

  logic sclk_fall, clr_fall, ld_fall, sync_fall;
  assign sclk_fall = clk_d_r && !sy_clk;
  assign clr_fall  = clr_d_r && !sy_clr;
  assign ld_fall   = ld_d_r && !sy_ld;
  assign sync_fall = (lo_d_r && !sy_lo) || (hi_d_r && !sy_hi);

  // Write engine state.
  dac_wr_pkg::wr_state_t                st_r, st_nxt;
  logic [dac_wr_pkg::FRAME_BITS-1:0]   sh_r, sh_nxt;   // Input shift register.
  logic [dac_wr_pkg::CNT_W-1:0]        cnt_r, cnt_nxt; // Bits captured.
  logic                                bank_r, bank_nxt; // 1 selects high bank.
  logic                                buf_on_r, buf_on_nxt;
  logic                                fb_in_ready, fb_out_valid, fb_out_ready;
  logic [FW-1:0]                       fb_out_data;
  logic                                push;

  // Framing and shifting.
  always_comb begin
    st_nxt     = st_r;
    sh_nxt     = sh_r;
    cnt_nxt    = cnt_r;
    bank_nxt   = bank_r;
    buf_on_nxt = buf_on_r;
    push       = 1'b0;
    case (st_r)
      dac_wr_pkg::ST_IDLE: begin
        // R1 arm on sync fall
        if (sync_fall) begin
          st_nxt     = dac_wr_pkg::ST_SHIFT;
          cnt_nxt    = '0;
          buf_on_nxt = 1'b1;
          // R4 bank from sync
          bank_nxt   = !sy_hi && sy_lo;
        end
      end
      dac_wr_pkg::ST_SHIFT: begin
        // R3 early rise aborts
        if ((bank_r ? sy_hi : sy_lo)) begin
          st_nxt     = dac_wr_pkg::ST_IDLE;
          buf_on_nxt = 1'b0;
        end else if (sclk_fall) begin
          // R2 R5 falling edge capture
          sh_nxt  = {sh_r[dac_wr_pkg::FRAME_BITS-2:0], sy_din};
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r == dac_wr_pkg::CNT_W'(dac_wr_pkg::FRAME_BITS - 1)) begin
            st_nxt = dac_wr_pkg::ST_DONE;
          end
        end
      end
      dac_wr_pkg::ST_DONE: begin
        // Holds until the buffer has room; stall loses no frame.
        if (fb_in_ready) begin
          push       = 1'b1;
          st_nxt     = dac_wr_pkg::ST_IDLE;
          buf_on_nxt = 1'b0;
        end
      end
      default: st_nxt = dac_wr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r     <= dac_wr_pkg::ST_IDLE;
      sh_r     <= '0;
      cnt_r    <= '0;
      bank_r   <= 1'b0;
      buf_on_r <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      sh_r     <= sh_nxt;
      cnt_r    <= cnt_nxt;
      bank_r   <= bank_nxt;
      buf_on_r <= buf_on_nxt;
    end
  end

  frame_buf #(.WIDTH(FW)) u_buf (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .in_data   ({bank_r, sh_r}),
    .in_valid  (push),
    .in_ready  (fb_in_ready),
    .out_data  (fb_out_data),
    .out_valid (fb_out_valid),
    .out_ready (fb_out_ready)
  );

  // Register file state.
  logic [dac_wr_pkg::CODE_W-1:0] in_r  [NCH], in_nxt  [NCH]; // Input registers.
  logic [dac_wr_pkg::CODE_W-1:0] dac_r [NCH], dac_nxt [NCH]; // DAC registers.
  logic [NCH-1:0]                pend_r, pend_nxt;            // New data pending.
  logic [1:0]                    ccode_r, ccode_nxt;          // Clear-code setting.
  logic [1:0]                    ref_r, ref_nxt;              // Internal reference per bank.
  logic [dac_wr_pkg::CODE_W-1:0] clr_val;
  logic [3:0]                    f_cmd, f_addr;
  logic [3:0]                    f_ch;
  logic                          ld_go;

  // Decode frames, load strobe and clear.
  always_comb begin
    in_nxt       = in_r;
    dac_nxt      = dac_r;
    pend_nxt     = pend_r;
    ccode_nxt    = ccode_r;
    ref_nxt      = ref_r;
    fb_out_ready = 1'b1;
    f_cmd  = fb_out_data[dac_wr_pkg::CMD_LSB +: 4];
    f_addr = fb_out_data[dac_wr_pkg::ADDR_LSB +: 4];
    // R4 high bank offsets by eight
    f_ch   = {fb_out_data[FW-1], f_addr[2:0]} ;
    case (ccode_r)
      dac_wr_pkg::CLR_MID:  clr_val = dac_wr_pkg::CODE_MID;
      dac_wr_pkg::CLR_FULL: clr_val = dac_wr_pkg::CODE_FULL;
      default:              clr_val = dac_wr_pkg::CODE_ZERO;
    endcase
    // R7 R10 load pulse, gated by clear
    ld_go = ld_fall && sy_clr;
    // Loads run before frame decode, so a word landing on the same channel keeps its pending mark.
    for (int i = 0; i < NCH; i++) begin
      // R8 held-low load auto-updates
      if (pend_r[i] && (ld_go || (!sy_ld && sy_clr))) begin
        dac_nxt[i]  = in_r[i];
        pend_nxt[i] = 1'b0;
      end
    end
    if (fb_out_valid) begin
      case (f_cmd)
        dac_wr_pkg::CMD_WR_IN, dac_wr_pkg::CMD_WR_UPD: begin
          in_nxt[f_ch[3:0]]   = fb_out_data[dac_wr_pkg::DATA_LSB +: dac_wr_pkg::CODE_W];
          pend_nxt[f_ch[3:0]] = 1'b1;
        end
        dac_wr_pkg::CMD_CLR_CODE: ccode_nxt = fb_out_data[1:0];
        dac_wr_pkg::CMD_REF_SET:  ref_nxt[fb_out_data[FW-1]] = fb_out_data[0];
        default: ;
      endcase
    end
    // Clear comes last, so it wins over loads and frames in the same cycle.
    for (int i = 0; i < NCH; i++) begin
      // R9 R11 clear on falling edge
      if (clr_fall) begin
        in_nxt[i]   = clr_val;
        dac_nxt[i]  = clr_val;
        pend_nxt[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NCH; i++) begin
        in_r[i]  <= '0;
        dac_r[i] <= '0;
      end
      pend_r  <= '0;
      // R12 zero scale default
      ccode_r <= dac_wr_pkg::CLR_ZERO;
      // R13 reference pins are inputs
      ref_r   <= 2'h0;
    end else begin
      in_r    <= in_nxt;
      dac_r   <= dac_nxt;
      pend_r  <= pend_nxt;
      ccode_r <= ccode_nxt;
      ref_r   <= ref_nxt;
    end
  end

  // Outputs straight from flip-flops.
  always_comb begin
    for (int i = 0; i < dac_wr_pkg::BANK_CH; i++) begin
      low_bank_outputs[i*dac_wr_pkg::CODE_W +: dac_wr_pkg::CODE_W]  = dac_r[i];
      high_bank_outputs[i*dac_wr_pkg::CODE_W +: dac_wr_pkg::CODE_W] = dac_r[i+dac_wr_pkg::BANK_CH];
    end
  end
  assign low_bank_reference_oe  = ref_r[0];
  assign high_bank_reference_oe = ref_r[1];
  assign serial_buffers_on      = buf_on_r;
  assign clear_code_sel         = ccode_r;

  // Assertions.
  sequence s_frame_done;
    st_r == dac_wr_pkg::ST_DONE;
  endsequence
  property p_arm;
    @(posedge core_clk) disable iff (!resetn)
    (st_r == dac_wr_pkg::ST_IDLE && sync_fall) |=> (buf_on_r && cnt_r == '0);
  endproperty
  a_arm: assert property (p_arm) else $error("Sync fall did not arm the frame."); // R1
  property p_count;
    @(posedge core_clk) disable iff (!resetn)
    (st_r == dac_wr_pkg::ST_SHIFT && sclk_fall && !(bank_r ? sy_hi : sy_lo)) |=> cnt_r == $past(cnt_r) + 1'b1;
  endproperty
  a_count: assert property (p_count) else $error("Bit count did not advance."); // R2
  property p_abort;
    @(posedge core_clk) disable iff (!resetn)
    (st_r == dac_wr_pkg::ST_SHIFT && (bank_r ? sy_hi : sy_lo)) |=> (st_r == dac_wr_pkg::ST_IDLE && !push);
  endproperty
  a_abort: assert property (p_abort) else $error("Aborted frame not dropped."); // R3
  property p_full;
    @(posedge core_clk) disable iff (!resetn)
    s_frame_done |-> cnt_r == dac_wr_pkg::CNT_W'(dac_wr_pkg::FRAME_BITS);
  endproperty
  a_full: assert property (p_full) else $error("Frame done without 32 bits."); // R5
  property p_load;
    @(posedge core_clk) disable iff (!resetn)
    (ld_go && pend_r[dac_wr_pkg::BANK_CH] && !clr_fall && !fb_out_valid) |=>
      (dac_r[dac_wr_pkg::BANK_CH] == $past(in_r[dac_wr_pkg::BANK_CH]) && !pend_r[dac_wr_pkg::BANK_CH]);
  endproperty
  a_load: assert property (p_load) else $error("Load pulse did not update."); // R7
  // Channel 2 is the low-bank channel the held-low load scenario writes.
  property p_auto;
    @(posedge core_clk) disable iff (!resetn)
    (pend_r[2] && !sy_ld && sy_clr && !clr_fall) |=> dac_r[2] == $past(in_r[2]);
  endproperty
  a_auto: assert property (p_auto) else $error("Held-low load did not update."); // R8
  property p_hold_clr;
    @(posedge core_clk) disable iff (!resetn)
    (!sy_clr && !clr_fall) |=> (low_bank_outputs == $past(low_bank_outputs) &&
                                high_bank_outputs == $past(high_bank_outputs));
  endproperty
  a_hold_clr: assert property (p_hold_clr) else $error("Load acted during clear."); // R10
  property p_clear;
    @(posedge core_clk) disable iff (!resetn)
    clr_fall |=> (in_r[NCH-1] == $past(clr_val) && dac_r[NCH-1] == $past(clr_val));
  endproperty
  a_clear: assert property (p_clear) else $error("Clear did not load the code."); // R11
  property p_ref;
    @(posedge core_clk) disable iff (!resetn)
    !fb_out_valid |=> ref_r == $past(ref_r);
  endproperty
  a_ref: assert property (p_ref) else $error("Reference select changed unprompted."); // R13
endmodule // dac_serial_wr

// ==== dv/host_serial_model.sv ====
/*
  Host serial master model that writes 32-bit frames into the DAC write port.
  Assumes the bench calls send from one process only; the link is async to core_clk.
*/
`timescale 1ns/1ns
module host_serial_model (
  output logic sync_low_n,  // Frame sync for channels 0-7, active low.
  output logic sync_high_n, // Frame sync for channels 8-15, active low.
  output logic sclk,        // Serial clock, idles high and stands still between frames.
  output logic sdin         // Serial data, MSB first.
);
  // Half periods give a 125 ns serial clock.
  localparam int HALF_HI = 62;
  localparam int HALF_LO = 63;
  logic last_bit; // Last data bit driven, kept to invert the released line.

  // Idle levels at time zero.
  initial begin
    sync_low_n  = 1'b1;
    sync_high_n = 1'b1;
    sclk        = 1'b1;
    sdin        = 1'b0;
    last_bit    = 1'b0;
  end

  // Sends the top nbits of word; fewer than 32 makes an aborted frame.
  task automatic send(input logic bank, input logic [31:0] word, input int nbits);
    int i;
    if (bank) sync_high_n = 1'b0;
    else sync_low_n = 1'b0;
    #HALF_LO;
    for (i = 31; i > 31 - nbits; i--) begin
      sdin     = word[i];
      last_bit = word[i];
      #HALF_HI;
      sclk = 1'b0;
      #HALF_LO;
      sclk = 1'b1;
    end
    #HALF_HI;
    sync_low_n  = 1'b1;
    sync_high_n = 1'b1;
    // The released data line shows the inverse of its last bit.
    sdin = ~last_bit;
    #40;
  endtask
endmodule // host_serial_model

// ==== dv/tb.sv ====
/*
  Self-checking testbench for the DAC serial write control block.
  Assumes the host model drives the serial pins and the bench drives load, clear and reset.
*/
`timescale 1ns/1ns
module tb;
  localparam int W = dac_wr_pkg::BANK_CH * dac_wr_pkg::CODE_W;
  logic         core_clk;     // Core clock.
  logic         resetn;       // Reset, active low.
  logic         load_n;       // Load strobe, active low.
  logic         clr_n;        // Clear input, active low.
  logic         sync_lo_n;    // Low bank sync.
  logic         sync_hi_n;    // High bank sync.
  logic         sclk;         // Serial clock.
  logic         sdin;         // Serial data.
  logic [W-1:0] low_out;      // Low bank codes.
  logic [W-1:0] high_out;     // High bank codes.
  logic [W-1:0] exp_lo;       // Expected low bank codes.
  logic [W-1:0] exp_hi;       // Expected high bank codes.
  logic         ref_lo;       // Low bank reference drive.
  logic         ref_hi;       // High bank reference drive.
  logic         buf_on;       // Serial buffers powered.
  logic [1:0]   clr_sel;      // Clear-code setting.
  int           bad_count;    // Mismatches seen.
  int           total_checks; // Comparisons made.

  // Core clock at 125 MHz.
  always #4 core_clk = ~core_clk;

  host_serial_model host (.sync_low_n(sync_lo_n), .sync_high_n(sync_hi_n), .sclk(sclk), .sdin(sdin));

  dac_serial_wr DUT (
    .core_clk(core_clk), .resetn(resetn), .frame_sync_low_bank_n(sync_lo_n),
    .frame_sync_high_bank_n(sync_hi_n), .dac_serial_clock(sclk), .dac_serial_input(sdin),
    .output_load_strobe_n(load_n), .clear_input_n(clr_n), .low_bank_outputs(low_out),
    .high_bank_outputs(high_out), .low_bank_reference_oe(ref_lo), .high_bank_reference_oe(ref_hi),
    .serial_buffers_on(buf_on), .clear_code_sel(clr_sel));

  // Compares one value and counts it.
  task automatic chk(input logic [W-1:0] seen, input logic [W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // Builds a frame from command, address, code and the low two bits.
  function automatic logic [31:0] frm(logic [3:0] c, logic [3:0] a, logic [11:0] d, logic [1:0] l);
    return {4'h0, c, a, d, 6'h00, l};
  endfunction

  // Lets a finished frame or strobe work through synchronisers and decode.
  task automatic settle();
    repeat (12) @(negedge core_clk);
  endtask

  // Compares both banks against the expected image.
  task automatic chk_banks();
    chk(low_out, exp_lo);
    chk(high_out, exp_hi);
  endtask

  // Prints the verdict and ends the run.
  task automatic report_and_stop();
    if (bad_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Reset values of every output.
  task automatic t_reset();
    chk_banks();
    chk(W'(clr_sel), W'(dac_wr_pkg::CLR_ZERO));
    chk(W'({ref_lo, ref_hi, buf_on}), '0);
  endtask

  // Two back-to-back frames with load held low update at once.
  task automatic t_auto();
    fork
      host.send(1'b0, frm(dac_wr_pkg::CMD_WR_UPD, 4'h2, 12'habc, 2'h0), 32);
      begin repeat (38) @(negedge core_clk); chk(W'(buf_on), W'(1)); end
    join
    host.send(1'b1, frm(dac_wr_pkg::CMD_WR_IN, 4'h5, 12'h5a5, 2'h0), 32);
    settle();
    exp_lo[2*12 +: 12] = 12'habc;
    exp_hi[5*12 +: 12] = 12'h5a5;
    chk_banks();
    chk(W'(buf_on), '0);
  endtask

  // Load held high defers updates until one strobe moves both banks.
  task automatic t_deferred();
    load_n = 1'b1;
    host.send(1'b0, frm(dac_wr_pkg::CMD_WR_IN, 4'h7, 12'h111, 2'h0), 32);
    host.send(1'b1, frm(dac_wr_pkg::CMD_WR_UPD, 4'h0, 12'h222, 2'h0), 32);
    settle();
    chk_banks();
    load_n = 1'b0;
    @(negedge core_clk);
    load_n = 1'b1;
    settle();
    exp_lo[7*12 +: 12] = 12'h111;
    exp_hi[0 +: 12]    = 12'h222;
    chk_banks();
  endtask

  // A frame cut at 31 bits changes nothing; a whole frame after it still lands cleanly.
  task automatic t_abort();
    load_n = 1'b0;
    host.send(1'b0, frm(dac_wr_pkg::CMD_WR_UPD, 4'h1, 12'hfff, 2'h0), 31);
    settle();
    chk_banks();
    host.send(1'b0, frm(dac_wr_pkg::CMD_WR_UPD, 4'h1, 12'h3c3, 2'h0), 32);
    settle();
    exp_lo[1*12 +: 12] = 12'h3c3;
    chk_banks();
  endtask

  // Every clear code, then a clear edge loading it everywhere.
  task automatic t_clear();
    logic [11:0] codes [3];
    codes = '{dac_wr_pkg::CODE_ZERO, dac_wr_pkg::CODE_MID, dac_wr_pkg::CODE_FULL};
    for (int k = 2; k >= 0; k--) begin
      host.send(1'b0, frm(dac_wr_pkg::CMD_CLR_CODE, 4'h0, 12'h000, 2'(k)), 32);
      settle();
      chk(W'(clr_sel), W'(k));
      clr_n = 1'b0;
      settle();
      exp_lo = {dac_wr_pkg::BANK_CH{codes[k]}};
      exp_hi = exp_lo;
      chk_banks();
      clr_n = 1'b1;
      settle();
    end
  endtask

  // While clear stays low a load pulse is ignored; after release it acts.
  task automatic t_clear_hold();
    load_n = 1'b1;
    clr_n  = 1'b0;
    settle();
    host.send(1'b1, frm(dac_wr_pkg::CMD_WR_IN, 4'h3, 12'h456, 2'h0), 32);
    settle();
    load_n = 1'b0;
    @(negedge core_clk);
    load_n = 1'b1;
    settle();
    chk_banks();
    clr_n = 1'b1;
    settle();
    load_n = 1'b0;
    @(negedge core_clk);
    load_n = 1'b1;
    settle();
    exp_hi[3*12 +: 12] = 12'h456;
    chk_banks();
  endtask

  // Internal reference drives only the bank it was set for.
  task automatic t_ref();
    host.send(1'b1, frm(dac_wr_pkg::CMD_REF_SET, 4'h0, 12'h000, 2'h1), 32);
    settle();
    chk(W'({ref_lo, ref_hi}), W'(2'b01));
    host.send(1'b1, frm(dac_wr_pkg::CMD_REF_SET, 4'h0, 12'h000, 2'h0), 32);
    settle();
    chk(W'({ref_lo, ref_hi}), '0);
  endtask

  // Main sequence.
  initial begin
    core_clk     = 1'b0;
    resetn       = 1'b0;
    load_n       = 1'b0;
    clr_n        = 1'b1;
    exp_lo       = '0;
    exp_hi       = '0;
    bad_count    = 0;
    total_checks = 0;
    repeat (20) @(negedge core_clk);
    resetn = 1'b1;
    repeat (4) @(negedge core_clk);
    t_reset();
    t_auto();
    t_deferred();
    t_abort();
    t_clear();
    t_clear_hold();
    t_ref();
    report_and_stop();
  end
endmodule // tb
